// file: isdl_pkg.sv
package isdl_pkg;
    // ----------------------------------------
    // address and word layout
    // ----------------------------------------
    localparam logic [5:0] ADDR_FIXED_SIX = 6'h06;
    localparam logic [4:0] ADDR_FIXED_FIVE = 5'h03;
    localparam int WORD_TOP_BIT = 15;
    localparam int POWER_MODE_MSB = 13;
    localparam int POWER_MODE_LSB = 12;
    localparam int DATA_TOP_BIT = 11;
    localparam int DATA_FIELD_WIDTH = 12;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // ----------------------------------------
    // power modes
    // ----------------------------------------
    localparam logic [1:0] PM_NORMAL = 2'h0;
    localparam logic [1:0] PM_LOAD_1K = 2'h1;
    localparam logic [1:0] PM_LOAD_100K = 2'h2;
    localparam logic [1:0] PM_HIZ = 2'h3;
    // ----------------------------------------
    // serial states
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_ADDR_ACK = 3'h3,
        ST_WR_BYTE = 3'h2,
        ST_WR_ACK = 3'h6,
        ST_RD_BYTE = 3'h7,
        ST_RD_ACK = 3'h5,
        ST_IGNORE = 3'h4
    } isdl_state_type;
endpackage

// file: isdl_edge_if.sv
`timescale 1ns/10ps
interface isdl_edge_if;
    logic level;
    logic rise;
    logic fall;
    modport source (output level, output rise, output fall);
    modport sink (input level, input rise, input fall);
endinterface

// file: isdl_edge_detect.sv
`timescale 1ns/10ps
module isdl_edge_detect
    import isdl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic lineIn,
    isdl_edge_if.source edge_o
);
    typedef struct packed {
        logic cur;
        logic prev;
    } isdl_edge_type;

    isdl_edge_type edge_reg;
    isdl_edge_type edge_next;

    // ----------------------------------------
    // sample and compare
    // ----------------------------------------
    always_comb begin
        edge_next.cur = lineIn;
        edge_next.prev = edge_reg.cur;
    end

    // idle bus lines rest high
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            edge_reg <= '{cur: 1'b1, prev: 1'b1};
        end else begin
            edge_reg <= edge_next;
        end
    end

    assign edge_o.level = edge_reg.cur;
    assign edge_o.rise = edge_reg.cur & ~edge_reg.prev;
    assign edge_o.fall = ~edge_reg.cur & edge_reg.prev;
endmodule // isdl_edge_detect

// file: isdl_dac_loader.sv
// What this block does
// [R1] Slave only; serial clock is an input, never driven.
// [R2] One-pin variant answers address 000110 plus low select pin.
// [R3] Two-pin variant answers 00011 plus both select pins.
// [R4] START (data falls, clock high) restarts byte framing.
// [R5] First byte: seven address bits then direction; one means read.
// [R6] On address match pull data low in ninth pulse; else stay released.
// [R7] Bytes are eight bits MSB first plus one acknowledge bit.
// [R8] Data changes only while clock low; stable while clock high.
// [R9] STOP (data rises, clock high) ends the addressed state.
// [R10] Master ends a write by raising data in the tenth pulse.
// [R11] Master ends a read with not-acknowledge then STOP.
// [R12] Write carries two data bytes; read returns one or two.
// [R13] Each further byte pair while addressed updates the output again.
// [R14] Repeated reads within one read transaction are allowed.
// [R15] Sixteen-bit word shifted in MSB first, upper byte first.
// [R16] Top two bits ignored; next two are the power-mode field.
// [R17] Data left-justified from bit 11; unused low bits ignored.
// [R18] Reset clears the converter word to zero.
// [R19] Write is address byte then two word bytes; address acknowledged.
// [R20] Power mode: 00 normal, 01 1k, 10 100k, 11 high impedance.
// [R21] Low hardware power-down pin forces high-impedance mode.
// [R22] Readback: one data byte at 8 bits, else two bytes.
// [R23] Power-down leaves the stored word unchanged.
// [R24] Update only after a full pair; a cut pair is dropped.
// [R25] Resolution and address pin count are build parameters.
`timescale 1ns/10ps
module isdl_dac_loader
    import isdl_pkg::*;
#(
    parameter int RESOLUTION = 12,
    parameter int ADDR_PINS = 2
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe_n,
    input wire logic addrSelectLow,
    input wire logic addrSelectHigh,
    input wire logic hwPowerdown_n,
    output logic [RESOLUTION-1:0] dacCode,
    output logic [1:0] powerMode,
    output logic dacUpdate,
    output logic addressed
);
    localparam logic [11:0] DATA_MASK = 12'hfff << (DATA_FIELD_WIDTH - RESOLUTION); // R17

    typedef struct packed {
        isdl_state_type st;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic [7:0] hiByte;
        logic [7:0] rdShift;
        logic rw;
        logic pairHalf;
        logic rdIdx;
        logic masterAck;
        logic drive;
        logic [15:0] word;
        logic commit;
        logic [RESOLUTION-1:0] code;
        logic [1:0] mode;
        logic update;
        logic addrd;
    } isdl_regs_type;

    isdl_regs_type r_reg;
    isdl_regs_type r_next;

    isdl_edge_if sclEdge ();
    isdl_edge_if sdaEdge ();

    // ----------------------------------------
    // line edge detection
    // ----------------------------------------
    isdl_edge_detect u_scl (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .lineIn(scl),
        .edge_o(sclEdge)
    );

    isdl_edge_detect u_sda (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .lineIn(sdaIn),
        .edge_o(sdaEdge)
    );

    logic startSeen;
    logic stopSeen;
    logic addrMatch;
    logic [6:0] ownAddr;

    // bus conditions only while the clock stays high
    assign startSeen = sdaEdge.fall & sclEdge.level & ~sclEdge.rise; // R4
    assign stopSeen = sdaEdge.rise & sclEdge.level & ~sclEdge.rise; // R9

    // ----------------------------------------
    // own address
    // ----------------------------------------
    always_comb begin
        if (ADDR_PINS == 1) begin
            ownAddr = {ADDR_FIXED_SIX, addrSelectLow}; // R2
        end else begin
            ownAddr = {ADDR_FIXED_FIVE, addrSelectHigh, addrSelectLow}; // R3 R25
        end
    end

    assign addrMatch = (r_reg.shift[7:1] == ownAddr); // R5

    // ----------------------------------------
    // readback byte select
    // ----------------------------------------
    function automatic logic [7:0] readByte(input logic [15:0] w, input logic idx);
        logic [7:0] b;
        b = idx ? w[7:0] : w[WORD_TOP_BIT -: 8];
        if (RESOLUTION == 8) begin
            b = w[DATA_TOP_BIT -: 8];
        end
        return b; // R22
    endfunction

    // ----------------------------------------
    // serial engine
    // ----------------------------------------
    always_comb begin
        r_next = r_reg;
        r_next.commit = 1'b0;
        if (startSeen) begin
            r_next.st = ST_ADDR; // R4
            r_next.bitCnt = 4'h0;
            r_next.pairHalf = 1'b0; // R24
            r_next.drive = 1'b0;
        end else if (stopSeen) begin
            r_next.st = ST_IDLE; // R9
            r_next.drive = 1'b0;
            r_next.pairHalf = 1'b0; // R24
        end else if (sclEdge.rise) begin
            case (r_reg.st)
                ST_ADDR, ST_WR_BYTE: begin
                    r_next.shift = {r_reg.shift[6:0], sdaEdge.level}; // R7 R8 R15
                    r_next.bitCnt = r_reg.bitCnt + 4'h1;
                end
                ST_RD_BYTE: begin
                    r_next.bitCnt = r_reg.bitCnt + 4'h1;
                end
                ST_RD_ACK: begin
                    r_next.masterAck = ~sdaEdge.level; // R11
                end
                default: begin
                    r_next.bitCnt = r_reg.bitCnt;
                end
            endcase
        end else if (sclEdge.fall) begin
            case (r_reg.st)
                ST_ADDR: begin
                    if (r_reg.bitCnt == BITS_PER_BYTE) begin
                        if (addrMatch) begin
                            r_next.st = ST_ADDR_ACK;
                            r_next.drive = 1'b1; // R6 R19
                            r_next.rw = r_reg.shift[0]; // R5
                        end else begin
                            r_next.st = ST_IGNORE; // R6
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    r_next.bitCnt = 4'h0;
                    r_next.rdIdx = 1'b0;
                    if (r_reg.rw) begin
                        r_next.st = ST_RD_BYTE;
                        r_next.rdShift = readByte(r_reg.word, 1'b0);
                        r_next.drive = ~r_next.rdShift[7]; // R7
                    end else begin
                        r_next.st = ST_WR_BYTE;
                        r_next.drive = 1'b0;
                        r_next.pairHalf = 1'b0;
                    end
                end
                ST_WR_BYTE: begin
                    if (r_reg.bitCnt == BITS_PER_BYTE) begin
                        r_next.st = ST_WR_ACK;
                        r_next.drive = 1'b1; // R7
                        if (!r_reg.pairHalf) begin
                            r_next.hiByte = r_reg.shift; // R15
                            r_next.pairHalf = 1'b1;
                        end else begin
                            r_next.pairHalf = 1'b0;
                            r_next.commit = 1'b1; // R12 R13 R24
                            r_next.word = {2'h0, r_reg.hiByte[5:4],
                                {r_reg.hiByte[3:0], r_reg.shift} & DATA_MASK}; // R16 R17
                        end
                    end
                end
                ST_WR_ACK: begin
                    r_next.st = ST_WR_BYTE;
                    r_next.drive = 1'b0;
                    r_next.bitCnt = 4'h0;
                end
                ST_RD_BYTE: begin
                    if (r_reg.bitCnt == BITS_PER_BYTE) begin
                        r_next.st = ST_RD_ACK;
                        r_next.drive = 1'b0;
                    end else begin
                        r_next.rdShift = {r_reg.rdShift[6:0], 1'b0};
                        r_next.drive = ~r_reg.rdShift[6]; // R7
                    end
                end
                ST_RD_ACK: begin
                    if (r_reg.masterAck) begin
                        r_next.st = ST_RD_BYTE; // R14
                        r_next.bitCnt = 4'h0;
                        r_next.rdIdx = ~r_reg.rdIdx;
                        r_next.rdShift = readByte(r_reg.word, ~r_reg.rdIdx);
                        r_next.drive = ~r_next.rdShift[7];
                    end else begin
                        r_next.st = ST_IGNORE; // R11
                    end
                end
                default: begin
                    r_next.drive = 1'b0;
                end
            endcase
        end
        // outputs follow the stored word one cycle later
        r_next.code = r_reg.word[DATA_TOP_BIT -: RESOLUTION]; // R17
        r_next.mode = hwPowerdown_n ?
            r_reg.word[POWER_MODE_MSB:POWER_MODE_LSB] : PM_HIZ; // R20 R21 R23
        r_next.update = r_reg.commit;
        r_next.addrd = (r_next.st != ST_IDLE) && (r_next.st != ST_IGNORE)
            && (r_next.st != ST_ADDR);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '0; // R18
            r_reg.st <= ST_IDLE;
            r_reg.mode <= PM_NORMAL;
        end else begin
            r_reg <= r_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // open drain: data low, enable low while pulling
    assign sdaOut = 1'b0;
    assign sdaOe_n = ~r_reg.drive; // R1 R6
    assign dacCode = r_reg.code;
    assign powerMode = r_reg.mode;
    assign dacUpdate = r_reg.update;
    assign addressed = r_reg.addrd;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence sAddrDone;
        r_reg.st == ST_ADDR && sclEdge.fall && !startSeen && !stopSeen
            && r_reg.bitCnt == BITS_PER_BYTE;
    endsequence

    sequence sPairDone;
        r_reg.st == ST_WR_BYTE && r_reg.pairHalf && sclEdge.fall
            && !startSeen && !stopSeen && r_reg.bitCnt == BITS_PER_BYTE;
    endsequence

    AST_START_FRAMES: assert property (startSeen |=> r_reg.st == ST_ADDR // R4
        && r_reg.bitCnt == 4'h0 && !r_reg.pairHalf)
        else $error("start did not restart framing");
    AST_STOP_ENDS: assert property (stopSeen && !startSeen |=> r_reg.st == ST_IDLE // R9
        && sdaOe_n ##1 !addressed)
        else $error("stop did not end addressed state");
    AST_ACK_MATCH: assert property (sAddrDone and addrMatch |=> !sdaOe_n) // R6
        else $error("matching address not acknowledged");
    AST_NO_ACK_MISS: assert property (sAddrDone and !addrMatch |=> sdaOe_n // R6
        && r_reg.st == ST_IGNORE)
        else $error("foreign address acknowledged");
    AST_IDLE_RELEASED: assert property (r_reg.st == ST_IDLE || r_reg.st == ST_IGNORE // R1
        |-> sdaOe_n)
        else $error("data line driven while not addressed");
    AST_PAIR_UPDATE: assert property (sPairDone |=> r_reg.commit ##1 dacUpdate // R13
        ##1 dacCode == $past(r_reg.word[DATA_TOP_BIT -: RESOLUTION], 2))
        else $error("complete pair did not update output");
    AST_CODE_ONLY_ON_COMMIT: assert property ($changed(r_reg.word) |-> $past(r_next.commit)) // R24
        else $error("word changed without a complete pair");
    AST_HW_POWERDOWN: assert property (!hwPowerdown_n |=> powerMode == PM_HIZ) // R21
        else $error("hardware power-down not forcing high impedance");
    AST_PD_KEEPS_WORD: assert property (powerMode != PM_NORMAL && !r_next.commit // R23
        |=> $stable(r_reg.word))
        else $error("power-down altered stored word");
    AST_MODE_DECODE: assert property (hwPowerdown_n ##1 hwPowerdown_n // R20
        |-> powerMode == $past(r_reg.word[POWER_MODE_MSB:POWER_MODE_LSB]))
        else $error("power mode field not applied");

    // ----------------------------------------
    // byte framing and acknowledge slots
    // ----------------------------------------
    sequence sWrByteDone;
        r_reg.st == ST_WR_BYTE && sclEdge.fall && r_reg.bitCnt == BITS_PER_BYTE;
    endsequence

    sequence sRdByteDone;
        r_reg.st == ST_RD_BYTE && sclEdge.fall && r_reg.bitCnt == BITS_PER_BYTE;
    endsequence

    // receiver acknowledges every written byte
    AST_WR_BYTE_ACK: assert property (sWrByteDone // R7
        |=> !sdaOe_n && r_reg.st == ST_WR_ACK)
        else $error("written byte not acknowledged");
    AST_WR_ACK_RELEASE: assert property (r_reg.st == ST_WR_ACK && sclEdge.fall // R7
        |=> sdaOe_n && r_reg.st == ST_WR_BYTE && r_reg.bitCnt == 4'h0)
        else $error("write acknowledge not released");
    // master answers read bytes, so the line is let go
    AST_RD_BYTE_RELEASE: assert property (sRdByteDone // R7
        |=> sdaOe_n && r_reg.st == ST_RD_ACK)
        else $error("read acknowledge slot not released");
    AST_NACK_ENDS_READ: assert property (r_reg.st == ST_RD_ACK && sclEdge.fall // R11
        && !r_reg.masterAck |=> r_reg.st == ST_IGNORE && sdaOe_n && !addressed)
        else $error("not-acknowledge did not end read");
    AST_ACK_REPEATS_READ: assert property (r_reg.st == ST_RD_ACK && sclEdge.fall // R14
        && r_reg.masterAck |=> r_reg.st == ST_RD_BYTE && r_reg.bitCnt == 4'h0)
        else $error("acknowledged read did not continue");
    AST_CUT_PAIR_DROP: assert property (startSeen || stopSeen // R24
        |=> !r_reg.pairHalf && !r_reg.commit)
        else $error("cut pair not discarded");
    // drive moves only after a clock fall, or when start or stop clears it
    AST_DRIVE_STABLE_HIGH: assert property (sclEdge.level // R8
        |=> $stable(sdaOe_n))
        else $error("data drive changed while clock high");
endmodule // isdl_dac_loader

// file: isdl_master_model.sv
`timescale 1ns/10ps
module isdl_master_model (
    input wire logic clk_sys,
    output logic scl,
    output logic sdaDrv,
    input wire logic sda
);
    // ----
    // line control, changes at falling clock edges
    // ----
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic start_cond();
        sdaDrv = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(3);
        sdaDrv = 1'b0;
        tick(3);
        scl = 1'b0;
        tick(2);
    endtask
    task automatic stop_cond();
        sdaDrv = 1'b0;
        tick(3);
        scl = 1'b1;
        tick(3);
        sdaDrv = 1'b1;
        tick(4);
    endtask
    // data set mid low phase, sampled mid high phase
    task automatic bit_cycle(input logic b, output logic r);
        sdaDrv = b;
        tick(3);
        scl = 1'b1;
        tick(2);
        r = sda;
        tick(2);
        scl = 1'b0;
        tick(2);
    endtask
    task automatic write_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(b[i], r);
        end
        bit_cycle(1'b1, r);
        ack = ~r;
    endtask
    task automatic read_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, d[i]);
        end
        bit_cycle(last, r);
    endtask
endmodule // isdl_master_model

// file: tb_top.sv
`timescale 1ns/10ps
module tb_top
    import isdl_pkg::*;
;
    logic clk_sys, rst_n, scl, sdaDrv, sda, sdaOut, sdaOe_n;
    logic addrSelectLow, addrSelectHigh, hwPowerdown_n, dacUpdate, addressed, ack;
    logic sdaOutSmall, sdaOeSmall_n, dacUpdateSmall, addressedSmall;
    logic [7:0] dacCodeSmall;
    logic [1:0] powerModeSmall;
    logic [11:0] dacCode;
    logic [1:0] powerMode;
    logic [6:0] addr;
    logic [15:0] w, last;
    logic [7:0] d [4];
    int fails, numChecks, updates, cycles, u0;
    // ----
    // pull-up wire and instances
    // ----
    assign sda = sdaDrv & (sdaOe_n | sdaOut) & (sdaOeSmall_n | sdaOutSmall);
    isdl_dac_loader #(.RESOLUTION(12), .ADDR_PINS(2)) isdl_dac_loader_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .scl(scl), .sdaIn(sda), .sdaOut(sdaOut),
        .sdaOe_n(sdaOe_n), .addrSelectLow(addrSelectLow), .addrSelectHigh(addrSelectHigh),
        .hwPowerdown_n(hwPowerdown_n), .dacCode(dacCode), .powerMode(powerMode),
        .dacUpdate(dacUpdate), .addressed(addressed));
    // one-pin eight-bit variant on the same bus, low pin inverted so addresses differ
    isdl_dac_loader #(.RESOLUTION(8), .ADDR_PINS(1)) isdl_dac_loader_inst_small (
        .clk_sys(clk_sys), .rst_n(rst_n), .scl(scl), .sdaIn(sda), .sdaOut(sdaOutSmall),
        .sdaOe_n(sdaOeSmall_n), .addrSelectLow(~addrSelectLow),
        .addrSelectHigh(addrSelectHigh), .hwPowerdown_n(hwPowerdown_n),
        .dacCode(dacCodeSmall), .powerMode(powerModeSmall),
        .dacUpdate(dacUpdateSmall), .addressed(addressedSmall));
    isdl_master_model isdl_master_model_inst (
        .clk_sys(clk_sys), .scl(scl), .sdaDrv(sdaDrv), .sda(sda));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (dacUpdate === 1'b1) begin
            updates++;
        end
        if (cycles == 40000) begin
            fails++;
            final_report();
        end
    end
    // ----
    // checking
    // ----
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        numChecks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        if (fails == 0 && numChecks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    function automatic logic [7:0] read_hi(input logic [15:0] x);
        return {2'h0, x[13:12], x[11:8]};
    endfunction
    function automatic logic [6:0] dev_addr();
        return {ADDR_FIXED_FIVE, addrSelectHigh, addrSelectLow};
    endfunction
    task automatic addr_phase(input logic rd);
        isdl_master_model_inst.start_cond();
        isdl_master_model_inst.write_byte({dev_addr(), rd}, ack);
        check("ack", {15'h0, ack}, 16'h1);
        check("addressed", {15'h0, addressed}, 16'h1);
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        rst_n = 1'b0;
        addrSelectLow = 1'b0;
        addrSelectHigh = 1'b0;
        hwPowerdown_n = 1'b1;
        fails = 0;
        numChecks = 0;
        updates = 0;
        cycles = 0;
        last = WORD_RESET;
        u0 = $urandom(32'hfd2751a2);
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        check("resetCode", {4'h0, dacCode}, WORD_RESET);
        check("resetOe", {15'h0, sdaOe_n}, 16'h1);
        // foreign address is not answered
        addr = {ADDR_FIXED_FIVE, ~addrSelectHigh, addrSelectLow};
        isdl_master_model_inst.start_cond();
        isdl_master_model_inst.write_byte({addr, 1'b0}, ack);
        check("foreignAck", {15'h0, ack}, 16'h0);
        isdl_master_model_inst.stop_cond();
        // random words, two pairs per transaction, all modes
        for (int i = 0; i < 8; i++) begin
            u0 = $urandom;
            addrSelectLow = u0[0];
            addrSelectHigh = u0[1];
            addr_phase(1'b0);
            for (int p = 0; p < 2; p++) begin
                w = 16'($urandom);
                w[13:12] = 2'(i + p);
                u0 = updates;
                isdl_master_model_inst.write_byte(w[15:8], ack);
                check("ackHi", {15'h0, ack}, 16'h1);
                isdl_master_model_inst.write_byte(w[7:0], ack);
                check("updates", 16'(updates), 16'(u0 + 1));
                check("code", {4'h0, dacCode}, {4'h0, w[11:0]});
                check("mode", {14'h0, powerMode}, {14'h0, w[13:12]});
                last = w;
            end
            isdl_master_model_inst.stop_cond();
            check("stopped", {15'h0, addressed}, 16'h0);
        end
        // pair cut short by stop
        addr_phase(1'b0);
        u0 = updates;
        isdl_master_model_inst.write_byte(~last[15:8], ack);
        isdl_master_model_inst.stop_cond();
        check("cutUpdates", 16'(updates), 16'(u0));
        check("cutCode", {4'h0, dacCode}, {4'h0, last[11:0]});
        // repeated readback
        addr_phase(1'b1);
        for (int k = 0; k < 4; k++) begin
            isdl_master_model_inst.read_byte(k == 3, d[k]);
            check("readback", {8'h0, d[k]}, {8'h0, k[0] ? last[7:0] : read_hi(last)});
        end
        isdl_master_model_inst.stop_cond();
        // one-pin eight-bit variant: write then repeated single-byte readback
        addr = {ADDR_FIXED_SIX, ~addrSelectLow};
        w = 16'($urandom);
        w[13:12] = PM_LOAD_100K;
        isdl_master_model_inst.start_cond();
        isdl_master_model_inst.write_byte({addr, 1'b0}, ack);
        check("smallAck", {15'h0, ack}, 16'h1);
        isdl_master_model_inst.write_byte(w[15:8], ack);
        isdl_master_model_inst.write_byte(w[7:0], ack);
        isdl_master_model_inst.stop_cond();
        check("smallCode", {8'h0, dacCodeSmall}, {8'h0, w[11:4]});
        check("smallMode", {14'h0, powerModeSmall}, {14'h0, w[13:12]});
        check("otherCode", {4'h0, dacCode}, {4'h0, last[11:0]});
        isdl_master_model_inst.start_cond();
        isdl_master_model_inst.write_byte({addr, 1'b1}, ack);
        isdl_master_model_inst.read_byte(1'b0, d[0]);
        isdl_master_model_inst.read_byte(1'b1, d[1]);
        isdl_master_model_inst.stop_cond();
        check("smallRead0", {8'h0, d[0]}, {8'h0, w[11:4]});
        check("smallRead1", {8'h0, d[1]}, {8'h0, w[11:4]});
        // hardware power-down
        hwPowerdown_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        check("pinMode", {14'h0, powerMode}, {14'h0, PM_HIZ});
        check("pinCode", {4'h0, dacCode}, {4'h0, last[11:0]});
        check("pinModeSmall", {14'h0, powerModeSmall}, {14'h0, PM_HIZ});
        hwPowerdown_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        check("modeBack", {14'h0, powerMode}, {14'h0, last[13:12]});
        check("modeBackSmall", {14'h0, powerModeSmall}, {14'h0, w[13:12]});
        final_report();
    end
endmodule // tb_top
